//--- verilog/link_sup_pkg.sv
// Constants, register map and carrier types of the link fault supervisor.
// Assumes a 20 MHz system clock and a frame parser in front of the block.
package link_sup_pkg;

    // Clock and timing
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned TICK_MS         = 100;
    localparam int unsigned TICK_CYCLES     = (CLK_HZ / 1000) * TICK_MS;
    localparam int unsigned TICKS_PER_SEC   = 1000 / TICK_MS;

    // Fault reaction codes
    localparam logic [1:0] REACT_STOP       = 2'h0;
    localparam logic [1:0] REACT_TIMED_STOP = 2'h1;
    localparam logic [1:0] REACT_WAIT       = 2'h2;
    localparam logic [1:0] REACT_CONTINUE   = 2'h3;

    // Limits
    localparam logic [9:0]  GRACE_MAX       = 10'h258;   // 60.0 s in 0.1 s
    localparam logic [5:0]  SILENCE_MAX     = 6'h3c;     // 60 s
    localparam logic [3:0]  ERR_LIMIT       = 4'h8;
    localparam logic [3:0]  RX_ERR_CAP      = 4'hf;
    localparam logic [15:0] PU_LIMIT        = 16'h4e20;  // 20000
    localparam logic [15:0] HZ_LIMIT        = 16'h9c40;  // 400.00 Hz
    localparam logic [7:0]  CODE_CHECKSUM   = 8'h47;     // 71
    localparam logic [7:0]  CODE_PARITY     = 8'h48;     // 72
    localparam logic [7:0]  CODE_OTHER      = 8'h49;     // 73
    localparam int unsigned RUN_ALARM_RESET_BIT = 15;

    // Link command items
    localparam logic [2:0] ITEM_PER_UNIT    = 3'h0;
    localparam logic [2:0] ITEM_HERTZ       = 3'h1;
    localparam logic [2:0] ITEM_RUN         = 3'h2;
    localparam logic [2:0] ITEM_DOUT        = 3'h3;
    localparam logic [2:0] ITEM_AOUT        = 3'h4;

    // Avalon byte addresses
    localparam logic [5:0] ADDR_REACT       = 6'h00;
    localparam logic [5:0] ADDR_GRACE       = 6'h04;
    localparam logic [5:0] ADDR_SILENCE     = 6'h08;
    localparam logic [5:0] ADDR_STATUS      = 6'h0c;
    localparam logic [5:0] ADDR_PU          = 6'h10;
    localparam logic [5:0] ADDR_HZ          = 6'h14;
    localparam logic [5:0] ADDR_RUN         = 6'h18;
    localparam logic [5:0] ADDR_DOUT        = 6'h1c;
    localparam logic [5:0] ADDR_AOUT        = 6'h20;
    localparam logic [5:0] ADDR_APPLIED     = 6'h24;

    // Reset values
    localparam logic [1:0] REACT_RESET      = 2'h0;
    localparam logic [9:0] GRACE_RESET      = 10'h000;
    localparam logic [5:0] SILENCE_RESET    = 6'h00;

    typedef enum logic [1:0] {
        ST_NORMAL   = 2'b00,
        ST_GRACE    = 2'b01,
        ST_CONTINUE = 2'b10,
        ST_TRIPPED  = 2'b11
    } sup_state_t;

    // Frame events from the parser, one-cycle pulses
    typedef struct packed {
        logic soh;          // Start-of-header seen
        logic sum_ok;       // Any station, checksum good
        logic sum_bad_own;  // Own station, checksum bad
        logic rx_parity;    // Character parity error
        logic rx_other;     // Framing, overrun, other
    } link_evt_t;

    // Command write decoded by the parser
    typedef struct packed {
        logic        valid;
        logic [2:0]  item;
        logic [15:0] data;
    } link_wr_t;

    // Commands actually applied to the drive
    typedef struct packed {
        logic        use_per_unit;
        logic [15:0] freq;
        logic [15:0] run;
        logic [15:0] dout;
        logic [15:0] aout;
    } applied_t;

endpackage

//--- verilog/tick_divider.sv
// Divider that issues a one-cycle enable every PERIOD clocks.
// Assumes one system clock and an asynchronous active-low reset.
`timescale 1ns/10ps
module tick_divider #(
    parameter int unsigned PERIOD = 2_000_000
) (
    input  wire logic i_sys_clk,
    input  wire logic i_rstn,
    output logic      o_tick
);
    logic [31:0] count;
    wire         wrap = (count == 32'(PERIOD - 1));

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            count  <= 32'h0;
            o_tick <= 1'b0;
        end else begin
            count  <= wrap ? 32'h0 : count + 32'h1;
            o_tick <= wrap;
        end
    end
endmodule // tick_divider

//--- verilog/serial_link_fault_supervisor.sv
// Fault supervisor for the multidrop serial command link of a drive.
// Assumes a frame parser supplies event pulses and decoded command writes,
// and software reaches the settings over Avalon-MM with waitrequest.
//
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps

// How it works
// - Reaction 0: stop at once and raise the link fault trip.
// - Reaction 1: keep running for the grace time, then stop and trip; a good frame before then resumes.
// - Reaction 2: run until recovery; trip if grace time expires first.
// - Reaction 3: keep running without trip, resume on recovery.
// - Grace time programmable 0.0 to 60.0 seconds.
// - Hold the commands in effect before the error while waiting.
// - Eight consecutive transmission errors make a communication error.
// - Own-station checksum failure counts an error, code 71.
// - Receive errors count: parity code 72, others code 73.
// - One receive error per frame; none past 15 until next header.
// - Any good-checksum frame clears the transmission error count.
// - Silence for the set time is an error; zero disables it.
// - Any good-checksum frame restarts the silence timer.
// - Nonzero per-unit setpoint wins over a nonzero hertz setpoint.
// - Per-unit setpoint spans -20000 to +20000 for maximum frequency.
// - Hertz setpoint in 0.01 Hz steps, 0.00 to 400.00 Hz.
// - Out-of-range command writes are kept but the applied value is clamped.
// - Reading a command item returns the last written value.
// - Alarm reset on falling alarm-reset bit, alarm or not.
// - Analogue output word spans -20000 to +20000 for full scale.
// - No reaction before first header or while not link-operated.
module serial_link_fault_supervisor #(
    parameter int unsigned TICK_CYCLES = link_sup_pkg::TICK_CYCLES
) (
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_rstn,
    // Link side
    input  wire link_sup_pkg::link_evt_t i_evt,
    input  wire link_sup_pkg::link_wr_t  i_wr,
    input  wire logic                    i_link_operating,
    // Avalon-MM slave
    input  wire logic [5:0]              i_avs_address,
    input  wire logic                    i_avs_read,
    input  wire logic                    i_avs_write,
    input  wire logic [31:0]             i_avs_writedata,
    output logic [31:0]                  o_avs_readdata,
    output logic                         o_avs_waitrequest,
    // Drive side
    output link_sup_pkg::applied_t       o_applied,
    output logic                         o_link_fault_trip,
    output logic                         o_force_stop,
    output logic                         o_alarm_reset,
    output logic [7:0]                   o_last_err_code
);

    // Clamp a signed word to +/- limit
    function automatic logic [15:0] clamp_signed(input logic [15:0] v,
                                                 input logic [15:0] lim);
        logic signed [15:0] s;
        s = signed'(v);
        if (s > signed'(lim))
            clamp_signed = lim;
        else if (s < -signed'(lim))
            clamp_signed = 16'(-signed'(lim));
        else
            clamp_signed = v;
    endfunction

    // Settings
    logic [1:0] fault_reaction_select;
    logic [9:0] fault_grace_time;
    logic [5:0] silence_detect_time;

    // Last written link commands
    logic [15:0] per_unit_setpoint;
    logic [15:0] hertz_setpoint;
    logic [15:0] run_command_word;
    logic [15:0] general_digital_out_word;
    logic [15:0] general_analog_out_word;

    // Supervision state
    link_sup_pkg::sup_state_t state;
    link_sup_pkg::sup_state_t next_state;
    logic        armed;
    logic [3:0]  err_cnt;
    logic [3:0]  rx_err_total;
    logic        rx_err_seen;
    logic [9:0]  grace_cnt;
    logic [9:0]  silence_cnt;
    logic        tick;

    tick_divider #(
        .PERIOD (TICK_CYCLES)
    ) u_tick (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .o_tick    (tick)
    );

    // Error counting
    wire rx_err_any   = i_evt.rx_parity | i_evt.rx_other;
    wire rx_err_count = rx_err_any & ~rx_err_seen
                        & (rx_err_total < link_sup_pkg::RX_ERR_CAP);
    wire err_inc      = i_evt.sum_bad_own | rx_err_count;
    wire [3:0] next_err_cnt = i_evt.sum_ok ? 4'h0 :
                              (err_inc && err_cnt != link_sup_pkg::ERR_LIMIT)
                              ? err_cnt + 4'h1 : err_cnt;
    wire burst_err    = (next_err_cnt == link_sup_pkg::ERR_LIMIT)
                        && (err_cnt != link_sup_pkg::ERR_LIMIT);

    // Silence detection in 0.1 s ticks
    wire [9:0] silence_limit = 10'(silence_detect_time)
                               * 10'(link_sup_pkg::TICKS_PER_SEC);
    wire silence_on  = (silence_detect_time != 6'h0);
    wire silence_err = silence_on && tick && (silence_cnt != silence_limit)
                       && (silence_cnt + 10'h1 == silence_limit);

    wire comm_err   = burst_err | silence_err;
    wire supervised = armed & i_link_operating;
    wire grace_done = (grace_cnt >= fault_grace_time);

    // Alarm reset edge of the link command bit
    wire alarm_bit  = run_command_word[link_sup_pkg::RUN_ALARM_RESET_BIT];
    wire run_wr     = i_wr.valid && i_wr.item == link_sup_pkg::ITEM_RUN;
    wire alarm_fall = run_wr && alarm_bit
                      && !i_wr.data[link_sup_pkg::RUN_ALARM_RESET_BIT];

    // Reaction state machine
    always_comb begin
        next_state = state;
        unique case (state)
            link_sup_pkg::ST_NORMAL: begin
                if (comm_err && supervised) begin
                    unique case (fault_reaction_select)
                        link_sup_pkg::REACT_STOP:
                            next_state = link_sup_pkg::ST_TRIPPED;
                        link_sup_pkg::REACT_TIMED_STOP:
                            next_state = link_sup_pkg::ST_GRACE;
                        link_sup_pkg::REACT_WAIT:
                            next_state = link_sup_pkg::ST_GRACE;
                        link_sup_pkg::REACT_CONTINUE:
                            next_state = link_sup_pkg::ST_CONTINUE;
                    endcase
                end
            end
            link_sup_pkg::ST_GRACE: begin
                if (i_evt.sum_ok)
                    next_state = link_sup_pkg::ST_NORMAL;
                else if (grace_done)
                    next_state = link_sup_pkg::ST_TRIPPED;
            end
            link_sup_pkg::ST_CONTINUE: begin
                if (i_evt.sum_ok)
                    next_state = link_sup_pkg::ST_NORMAL;
            end
            link_sup_pkg::ST_TRIPPED: begin
                if (alarm_fall)
                    next_state = link_sup_pkg::ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn)
            state <= link_sup_pkg::ST_NORMAL;
        else
            state <= next_state;
    end

    // First header arms the supervisor
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn)
            armed <= 1'b0;
        else if (i_evt.soh)
            armed <= 1'b1;
    end

    // Transmission error bookkeeping
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            err_cnt      <= 4'h0;
            rx_err_total <= 4'h0;
            rx_err_seen  <= 1'b0;
        end else begin
            err_cnt <= next_err_cnt;
            if (i_evt.soh) begin
                rx_err_total <= 4'h0;
                rx_err_seen  <= 1'b0;
            end else if (rx_err_count) begin
                rx_err_total <= rx_err_total + 4'h1;
                rx_err_seen  <= 1'b1;
            end
        end
    end

    // Last error code, newest wins
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn)
            o_last_err_code <= 8'h00;
        else if (i_evt.sum_bad_own)
            o_last_err_code <= link_sup_pkg::CODE_CHECKSUM;
        else if (rx_err_count && i_evt.rx_parity)
            o_last_err_code <= link_sup_pkg::CODE_PARITY;
        else if (rx_err_count)
            o_last_err_code <= link_sup_pkg::CODE_OTHER;
    end

    // Silence timer; saturates so one silent spell gives one error
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn)
            silence_cnt <= 10'h0;
        else if (i_evt.sum_ok || !silence_on)
            silence_cnt <= 10'h0;
        else if (tick && silence_cnt != silence_limit)
            silence_cnt <= silence_cnt + 10'h1;
    end

    // Grace timer, 0.1 s resolution
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn)
            grace_cnt <= 10'h0;
        else if (state != link_sup_pkg::ST_GRACE)
            grace_cnt <= 10'h0;
        else if (tick && !grace_done)
            grace_cnt <= grace_cnt + 10'h1;
    end

    // Last written link commands, stored unclamped
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            per_unit_setpoint        <= 16'h0;
            hertz_setpoint           <= 16'h0;
            run_command_word         <= 16'h0;
            general_digital_out_word <= 16'h0;
            general_analog_out_word  <= 16'h0;
        end else if (i_wr.valid) begin
            unique case (i_wr.item)
                link_sup_pkg::ITEM_PER_UNIT:
                    per_unit_setpoint <= i_wr.data;
                link_sup_pkg::ITEM_HERTZ:
                    hertz_setpoint <= i_wr.data;
                link_sup_pkg::ITEM_RUN:
                    run_command_word <= i_wr.data;
                link_sup_pkg::ITEM_DOUT:
                    general_digital_out_word <= i_wr.data;
                link_sup_pkg::ITEM_AOUT:
                    general_analog_out_word <= i_wr.data;
                default: ;
            endcase
        end
    end

    // Applied command, derived from the written words
    wire use_pu = (per_unit_setpoint != 16'h0);
    wire [15:0] hz_clamped = (hertz_setpoint > link_sup_pkg::HZ_LIMIT)
                             ? link_sup_pkg::HZ_LIMIT
                             : hertz_setpoint;
    wire [15:0] pu_clamped = clamp_signed(per_unit_setpoint,
                                          link_sup_pkg::PU_LIMIT);
    wire [15:0] ao_clamped = clamp_signed(general_analog_out_word,
                                          link_sup_pkg::PU_LIMIT);
    wire hold = (state != link_sup_pkg::ST_NORMAL);

    // Frozen outside ST_NORMAL so a stale parser cannot steer the drive; run zeroed once tripped
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_applied <= '0;
        end else if (!hold) begin
            o_applied.use_per_unit <= use_pu;
            o_applied.freq <= use_pu ? pu_clamped : hz_clamped;
            o_applied.run  <= run_command_word;
            o_applied.dout <= general_digital_out_word;
            o_applied.aout <= ao_clamped;
        end else if (state == link_sup_pkg::ST_TRIPPED) begin
            o_applied.run <= 16'h0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_link_fault_trip <= 1'b0;
            o_force_stop      <= 1'b0;
            o_alarm_reset     <= 1'b0;
        end else begin
            o_link_fault_trip <= (next_state == link_sup_pkg::ST_TRIPPED);
            o_force_stop      <= (next_state == link_sup_pkg::ST_TRIPPED);
            o_alarm_reset     <= alarm_fall;
        end
    end

    // Avalon-MM slave: one wait cycle, then the access completes
    wire req      = i_avs_read | i_avs_write;
    wire complete = req & ~o_avs_waitrequest;
    wire wr_en    = i_avs_write & complete;
    wire [15:0] status_word = {6'h0, armed, i_link_operating,
                               rx_err_total, err_cnt};
    wire [31:0] status_full = {14'h0, state, status_word};
    logic [31:0] rd_mux;

    always_comb begin
        unique case (i_avs_address)
            link_sup_pkg::ADDR_REACT:   rd_mux = {30'h0,
                                                  fault_reaction_select};
            link_sup_pkg::ADDR_GRACE:   rd_mux = {22'h0, fault_grace_time};
            link_sup_pkg::ADDR_SILENCE: rd_mux = {26'h0, silence_detect_time};
            link_sup_pkg::ADDR_STATUS:  rd_mux = status_full;
            link_sup_pkg::ADDR_PU:      rd_mux = {16'h0,
                                                  per_unit_setpoint};
            link_sup_pkg::ADDR_HZ:      rd_mux = {16'h0, hertz_setpoint};
            link_sup_pkg::ADDR_RUN:     rd_mux = {16'h0, run_command_word};
            link_sup_pkg::ADDR_DOUT:    rd_mux = {16'h0,
                                                  general_digital_out_word};
            link_sup_pkg::ADDR_AOUT:    rd_mux = {16'h0,
                                                  general_analog_out_word};
            link_sup_pkg::ADDR_APPLIED: rd_mux = {o_applied.use_per_unit,
                                                  15'h0, o_applied.freq};
            default:                    rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= 32'h0;
        end else begin
            o_avs_waitrequest <= ~(req & o_avs_waitrequest);
            if (i_avs_read && o_avs_waitrequest)
                o_avs_readdata <= rd_mux;
        end
    end

    // Settings writes; out-of-range values are clamped on entry
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            fault_reaction_select <= link_sup_pkg::REACT_RESET;
            fault_grace_time      <= link_sup_pkg::GRACE_RESET;
            silence_detect_time   <= link_sup_pkg::SILENCE_RESET;
        end else if (wr_en) begin
            unique case (i_avs_address)
                link_sup_pkg::ADDR_REACT:
                    fault_reaction_select <= i_avs_writedata[1:0];
                link_sup_pkg::ADDR_GRACE:
                    fault_grace_time <=
                        (i_avs_writedata[9:0] > link_sup_pkg::GRACE_MAX)
                        ? link_sup_pkg::GRACE_MAX
                        : i_avs_writedata[9:0];
                link_sup_pkg::ADDR_SILENCE:
                    silence_detect_time <=
                        (i_avs_writedata[5:0] > link_sup_pkg::SILENCE_MAX)
                        ? link_sup_pkg::SILENCE_MAX
                        : i_avs_writedata[5:0];
                default: ;
            endcase
        end
    end

endmodule // serial_link_fault_supervisor

//--- sim/link_host_model.sv
// Host side of the serial link, as seen after frame parsing.
// Assumes the bench calls its tasks; outputs move just after an edge.
`timescale 1ns/10ps
module link_host_model (
    input  wire logic               i_sys_clk,
    output link_sup_pkg::link_evt_t o_evt = '0,
    output link_sup_pkg::link_wr_t  o_wr = '0
);
    // One pulse a call, then an idle cycle
    task automatic evt(input link_sup_pkg::link_evt_t e);
        @(posedge i_sys_clk);
        o_evt <= e;
        @(posedge i_sys_clk);
        o_evt <= '0;
    endtask
    // Stale data is inverted once valid drops
    task automatic wr(input logic [2:0] item, input logic [15:0] d);
        @(posedge i_sys_clk);
        o_wr <= {1'b1, item, d};
        @(posedge i_sys_clk);
        o_wr <= {1'b0, item, ~d};
    endtask
endmodule // link_host_model

//--- sim/serial_link_fault_supervisor_checker.sv
// Port checker for the link fault supervisor.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/10ps
module link_sup_checker (
    input wire logic                    i_sys_clk,
    input wire logic                    i_rstn,
    input wire link_sup_pkg::link_evt_t i_evt,
    input wire link_sup_pkg::link_wr_t  i_wr,
    input wire logic                    i_avs_read,
    input wire logic                    i_avs_write,
    input wire logic                    o_avs_waitrequest,
    input wire link_sup_pkg::applied_t  o_applied,
    input wire logic                    o_link_fault_trip,
    input wire logic                    o_force_stop,
    input wire logic                    o_alarm_reset,
    input wire logic [7:0]              o_last_err_code
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_req;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence s_held;
        o_link_fault_trip [*2];
    endsequence
    a_one_wait: assert property (s_req |=> !o_avs_waitrequest)
        else $error("no answer after one wait state");
    a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low too long");
    a_stop_trip: assert property (o_force_stop == o_link_fault_trip)
        else $error("stop and trip differ");
    a_reset_pulse: assert property (
        o_alarm_reset |=> !o_alarm_reset)
        else $error("alarm reset not a pulse");
    // Slack of two cycles for the run word store
    a_trip_holds: assert property (o_link_fault_trip && !i_wr.valid
        && !$past(i_wr.valid) && !$past(i_wr.valid, 2) |=> o_link_fault_trip)
        else $error("trip dropped without alarm reset");
    a_run_cleared: assert property (
        s_held |-> o_applied.run == 16'h0)
        else $error("run word live while tripped");
    a_freq_clamp: assert property (o_applied.use_per_unit ?
        ($signed(o_applied.freq) <= 16'sd20000 &&
         $signed(o_applied.freq) >= -16'sd20000)
        : (o_applied.freq <= 16'h9c40))
        else $error("applied frequency out of range");
    a_code_cause: assert property (o_last_err_code != 8'h0 &&
        $changed(o_last_err_code) |->
        (o_last_err_code == 8'h47 && $past(i_evt.sum_bad_own)) ||
        (o_last_err_code == 8'h48 && $past(i_evt.rx_parity)) ||
        (o_last_err_code == 8'h49 && $past(i_evt.rx_other)))
        else $error("error code without its cause");
endmodule // link_sup_checker
bind serial_link_fault_supervisor link_sup_checker u_chk (.i_sys_clk,
    .i_rstn, .i_evt, .i_wr, .i_avs_read, .i_avs_write, .o_avs_waitrequest,
    .o_applied, .o_link_fault_trip, .o_force_stop, .o_alarm_reset,
    .o_last_err_code);

//--- sim/test_serial_link_fault_supervisor.sv
// Self-checking bench for the link fault supervisor.
// Assumes host model and checker are compiled before it.
`timescale 1ns/10ps
module test_serial_link_fault_supervisor;
    logic                    clk = 1'b0;
    logic                    rstn = 1'b0;
    logic                    op = 1'b0;
    logic [5:0]              adr = 6'h0;
    logic                    rd = 1'b0;
    logic                    wr = 1'b0;
    logic [31:0]             wd = 32'h0;
    logic [31:0]             rdata;
    logic [31:0]             q;
    logic                    wreq;
    logic                    trip;
    logic                    stop;
    logic                    arst;
    logic [7:0]              code;
    link_sup_pkg::link_evt_t evt;
    link_sup_pkg::link_wr_t  lw;
    link_sup_pkg::applied_t  app;
    int                      bad_count = 0;
    int                      cmp_count = 0;
    int                      cyc = 0;
    logic [1:0]              ex [4] = '{2'h3, 2'h1, 2'h1, 2'h2};
    always #25 clk = ~clk;
    link_host_model host (.i_sys_clk(clk), .o_evt(evt), .o_wr(lw));
    serial_link_fault_supervisor #(.TICK_CYCLES(10)) uut (.i_sys_clk(clk),
        .i_rstn(rstn), .i_evt(evt), .i_wr(lw), .i_link_operating(op),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wreq), .o_applied(app), .o_link_fault_trip(trip),
        .o_force_stop(stop), .o_alarm_reset(arst), .o_last_err_code(code));
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(logic w, logic [5:0] a, logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic st(logic [1:0] s, logic [3:0] n);
        bus(1'b0, 6'h0c, 32'h0);
        chk("state", q[17:16], s);
        chk("err_cnt", q[3:0], n);
    endtask
    task automatic summarize();
        if (bad_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            summarize();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        op <= 1'b1;
        bus(1'b1, 6'h3c, 32'hff);
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, (i == 3) ? 6'h3c : 6'(i * 4), 32'h0);
            chk("reset value", q, 32'h0);
        end
        bus(1'b1, 6'h04, 32'h2bc);
        bus(1'b0, 6'h04, 32'h0);
        chk("grace", q, 32'h258);
        bus(1'b1, 6'h08, 32'h3d);
        bus(1'b0, 6'h08, 32'h0);
        chk("silence", q, 32'h3c);
        // Not armed yet: errors must not trip
        repeat (8) host.evt(5'h04);
        chk("trip", trip, 1'b0);
        chk("code", code, 8'h47);
        host.evt(5'h08);
        st(2'h0, 4'h0);
        host.evt(5'h10);
        host.evt(5'h02);
        host.evt(5'h02);
        st(2'h0, 4'h1);
        chk("code", code, 8'h48);
        host.evt(5'h10);
        host.evt(5'h01);
        st(2'h0, 4'h2);
        chk("code", code, 8'h49);
        host.wr(3'h0, 16'h0);
        host.wr(3'h1, 16'hc350);
        repeat (2) @(posedge clk);
        bus(1'b0, 6'h24, 32'h0);
        chk("hz applied", q, 32'h9c40);
        host.wr(3'h0, 16'h8ad0);
        repeat (2) @(posedge clk);
        bus(1'b0, 6'h10, 32'h0);
        chk("pu raw", q, 32'h8ad0);
        bus(1'b0, 6'h24, 32'h0);
        chk("pu applied", q, 32'h8000b1e0);
        host.wr(3'h4, 16'h4e21);
        host.wr(3'h3, 16'h00a5);
        bus(1'b0, 6'h20, 32'h0);
        chk("ao raw", q, 32'h4e21);
        chk("ao applied", app.aout, 16'h4e20);
        chk("do applied", app.dout, 16'h00a5);
        bus(1'b1, 6'h04, 32'h5);
        bus(1'b1, 6'h08, 32'h0);
        // Link not in charge: a burst must not react
        op <= 1'b0;
        repeat (8) host.evt(5'h04);
        st(2'h0, 4'h8);
        op <= 1'b1;
        for (int r = 0; r < 4; r++) begin
            bus(1'b1, 6'h00, 32'(r));
            host.evt(5'h08);
            repeat (8) host.evt(5'h04);
            st(ex[r], 4'h8);
            chk("trip", trip, r == 0);
            chk("stop", stop, r == 0);
            if (r == 1) begin
                host.wr(3'h0, 16'h0064);
                bus(1'b0, 6'h24, 32'h0);
                chk("held", q, 32'h8000b1e0);
                repeat (60) @(posedge clk);
                chk("trip", trip, 1'b1);
            end
            if (r > 1) begin
                host.evt(5'h08);
                st(2'h0, 4'h0);
            end
            host.wr(3'h2, 16'h8000);
            host.wr(3'h2, 16'h0000);
            @(negedge clk);
            chk("alarm reset", arst, 1'b1);
            repeat (2) @(posedge clk);
            chk("trip", trip, 1'b0);
        end
        // Reaction 2 with no recovery: forced stop once grace runs out
        bus(1'b1, 6'h00, 32'h2);
        host.wr(3'h2, 16'h0001);
        repeat (8) host.evt(5'h04);
        repeat (60) @(posedge clk);
        chk("trip", trip, 1'b1);
        chk("run", app.run, 16'h0);
        host.wr(3'h2, 16'h8000);
        host.wr(3'h2, 16'h0000);
        bus(1'b1, 6'h00, 32'h3);
        bus(1'b1, 6'h08, 32'h1);
        host.evt(5'h08);
        repeat (80) @(posedge clk);
        host.evt(5'h08);
        repeat (80) @(posedge clk);
        st(2'h0, 4'h0);
        repeat (40) @(posedge clk);
        st(2'h2, 4'h0);
        summarize();
    end
endmodule // test_serial_link_fault_supervisor
